// File: core/tsf_defs.svh
/*
 * Register offsets, field positions, reset values and fault vectors
 * of the task switch segment fault checker.
 * Assumes a 32-bit APB with byte addresses in the low eight bits.
 */
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH

`define TSF_OFF_CTRL    8'h00
`define TSF_OFF_TSS     8'h04
`define TSF_OFF_LDT     8'h08
`define TSF_OFF_SEG0    8'h0C
`define TSF_OFF_IPOLD   8'h18
`define TSF_OFF_IPNEW   8'h1C
`define TSF_OFF_STATUS  8'h20
`define TSF_OFF_ERR     8'h24
`define TSF_OFF_SAVEDIP 8'h28
`define TSF_OFF_TASK    8'h2C

`define TSF_CTRL_GO     0
`define TSF_CTRL_OP     3:1
`define TSF_CTRL_CPL    5:4
`define TSF_CTRL_EXT    6
`define TSF_CTRL_IDT    7
`define TSF_CTRL_T32    8
`define TSF_CTRL_CALL   9
`define TSF_CTRL_TPRES  10
`define TSF_CTRL_SLOT   12:11

`define TSF_SEG_OVER    16
`define TSF_SEG_ACC     17
`define TSF_SEG_CONF    18
`define TSF_SEG_PRES    19
`define TSF_SEG_DPL     21:20

`define TSF_RST_WORD    32'h0000_0000
`define TSF_LIM32       16'h0067
`define TSF_LIM16       16'h002C

`define TSF_VEC_OVERRUN 8'h09
`define TSF_VEC_TS      8'h0A
`define TSF_VEC_NP      8'h0B
`define TSF_VEC_SS      8'h0C
`define TSF_VEC_GP      8'h0D

`endif

// File: core/tsf_pkg.sv
/*
 * Types of the task switch segment fault checker.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tsf_pkg;

    typedef enum logic [2:0]
    {
        OP_SWITCH, OP_LOADSEG, OP_LOAD_LOCAL_TABLE_INSTR, OP_LTR, OP_GATE, OP_COPROC
    } tsf_op_t;

    typedef enum logic [2:0]
    {
        S_IDLE, S_ONE, S_TSS, S_COMMIT, S_LOAD, S_LDT, S_SEG
    } tsf_state_t;

    typedef struct packed
    {
        tsf_state_t  st;
        tsf_op_t     op;
        logic [1:0]  current_privilege_level;
        logic        outside_event_flag;
        logic        interrupt_descriptor_table;
        logic        t32;
        logic        call;
        logic        tpres;
        logic [1:0]  slot;
        logic [31:0] task_state_segment;
        logic [31:0] local_descriptor_table;
        logic [2:0][31:0] seg;
        logic [31:0] ip_old;
        logic [31:0] ip_new;
        logic [1:0]  idx;
        logic        busy;
        logic        done;
        logic        fault;
        logic        new_ctx;
        logic        has_code;
        logic        loaded;
        logic [7:0]  vec;
        logic [15:0] err;
        logic [31:0] saved_ip;
        logic [15:0] tr_sel;
        logic [15:0] link_sel;
        logic [31:0] prdata;
    } tsf_regs_t;

endpackage

// File: core/tsf_desc_check.sv
/*
 * Validity test of one segment named by an incoming task segment.
 * Slot 0 is the stack, 1 the code, 2 a data segment.
 * Assumes descriptor attributes are already fetched by the caller.
 */
`timescale 1ns/100ps
`default_nettype none
module tsf_desc_check
    import tsf_pkg::*;
#(
    parameter logic [1:0] SLOT = 2'd0
)
(
    // Descriptor attributes
    input  wire logic       over,
    input  wire logic       acc,
    input  wire logic       conf,
    input  wire logic       pres,
    input  wire logic [1:0] descriptor_privilege_level,
    input  wire logic [1:0] requested_privilege_level,
    input  wire logic [1:0] current_privilege_level,
    // Verdict
    output logic            bad,
    output logic            absent
);

    always_comb
    begin
        absent = !pres;
        unique case (SLOT)
            2'd0:    bad = over || !acc || descriptor_privilege_level != current_privilege_level
                           || requested_privilege_level != current_privilege_level;
            2'd1:    bad = over || !acc
                           || (!conf && descriptor_privilege_level != current_privilege_level)
                           || (conf && descriptor_privilege_level > current_privilege_level);
            default: bad = over || !acc;
        endcase
    end

endmodule
`default_nettype wire

// File: core/tsf_checker.sv
/*
 * Task switch segment fault checker with an APB register file.
 * Software posts descriptor attributes, starts a check through CTRL,
 * and reads back vector, error code, saved pointer and context.
 * Assumes one clock, synchronous inputs and a zero wait APB master.
 */
// Added by the designer: the register offsets and the APB register port.
`include "tsf_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tsf_checker
    import tsf_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Fault report to the core
    output logic             exc_valid,
    output logic [7:0]       exc_vector,
    output logic [15:0]      exc_error,
    output logic             exc_has_code,
    output logic             exc_new_ctx,
    output logic [31:0]      exc_ip,
    output logic             segs_loaded
);

    tsf_regs_t s;
    tsf_regs_t next_s;
    logic [2:0] bad;
    logic [2:0] absent;
    logic       setup;
    logic       wr;
    logic       mapped;
    logic       go;

    // ------------------------------------------------------------
    // Selector error codes
    // ------------------------------------------------------------
    function automatic logic [15:0] mk_err(
        input logic [15:0] sel,
        input logic        interrupt_descriptor_table,
        input logic        outside_event_flag
    );
        return {sel[15:3], sel[2], interrupt_descriptor_table, outside_event_flag};
    endfunction

    function automatic tsf_regs_t raise(
        input tsf_regs_t   r,
        input logic [7:0]  v,
        input logic [15:0] e,
        input logic        hc,
        input logic        nc,
        input logic [31:0] ip
    );
        tsf_regs_t o;
        o = r;
        o.fault = 1'b1;
        o.vec = v;
        o.err = e;
        o.has_code = hc;
        o.new_ctx = nc;
        o.saved_ip = ip;
        o.done = 1'b1;
        o.busy = 1'b0;
        o.st = S_IDLE;
        return o;
    endfunction

    function automatic tsf_regs_t finish(input tsf_regs_t r);
        tsf_regs_t o;
        o = r;
        o.done = 1'b1;
        o.busy = 1'b0;
        o.st = S_IDLE;
        return o;
    endfunction

    // ------------------------------------------------------------
    // Segment checks
    // ------------------------------------------------------------
    generate
        for (genvar gi = 0; gi < 3; gi++)
        begin : g_chk
            tsf_desc_check #(.SLOT(2'(gi))) u_chk (
                .over   (s.seg[gi][`TSF_SEG_OVER]),
                .acc    (s.seg[gi][`TSF_SEG_ACC]),
                .conf   (s.seg[gi][`TSF_SEG_CONF]),
                .pres   (s.seg[gi][`TSF_SEG_PRES]),
                .descriptor_privilege_level    (s.seg[gi][`TSF_SEG_DPL]),
                .requested_privilege_level    (s.seg[gi][1:0]),
                .current_privilege_level    (s.current_privilege_level),
                .bad    (bad[gi]),
                .absent (absent[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    always_comb
    begin
        setup = psel && !penable;
        wr = psel && penable && pwrite && ce;
        unique case (paddr)
            `TSF_OFF_CTRL, `TSF_OFF_TSS, `TSF_OFF_LDT,
            `TSF_OFF_SEG0, `TSF_OFF_SEG0 + 8'h04,
            `TSF_OFF_SEG0 + 8'h08, `TSF_OFF_IPOLD,
            `TSF_OFF_IPNEW, `TSF_OFF_STATUS, `TSF_OFF_ERR,
            `TSF_OFF_SAVEDIP, `TSF_OFF_TASK:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
        // A start while busy is dropped, so one switch gives one report
        go = wr && paddr == `TSF_OFF_CTRL
             && pwdata[`TSF_CTRL_GO] && !s.busy;
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                `TSF_OFF_CTRL:
                    next_s.prdata = {19'h0_0000, s.slot, s.tpres,
                                     s.call, s.t32, s.interrupt_descriptor_table, s.outside_event_flag,
                                     s.current_privilege_level, s.op, 1'b0};
                `TSF_OFF_TSS:   next_s.prdata = s.task_state_segment;
                `TSF_OFF_LDT:   next_s.prdata = s.local_descriptor_table;
                `TSF_OFF_SEG0:  next_s.prdata = s.seg[0];
                `TSF_OFF_SEG0 + 8'h04:
                    next_s.prdata = s.seg[1];
                `TSF_OFF_SEG0 + 8'h08:
                    next_s.prdata = s.seg[2];
                `TSF_OFF_IPOLD: next_s.prdata = s.ip_old;
                `TSF_OFF_IPNEW: next_s.prdata = s.ip_new;
                `TSF_OFF_STATUS:
                    next_s.prdata = {16'h0000, s.vec, 2'b00,
                                     s.loaded, s.has_code,
                                     s.new_ctx, s.fault,
                                     s.done, s.busy};
                `TSF_OFF_ERR:   next_s.prdata = {16'h0000, s.err};
                `TSF_OFF_SAVEDIP:
                    next_s.prdata = s.saved_ip;
                `TSF_OFF_TASK:
                    next_s.prdata = {s.link_sel, s.tr_sel};
                default:        next_s.prdata = `TSF_RST_WORD;
            endcase
        end
        // Inputs are frozen while a check walks through them
        if (wr && !s.busy)
        begin
            unique case (paddr)
                `TSF_OFF_TSS:   next_s.task_state_segment = pwdata;
                `TSF_OFF_LDT:   next_s.local_descriptor_table = pwdata;
                `TSF_OFF_SEG0:  next_s.seg[0] = pwdata;
                `TSF_OFF_SEG0 + 8'h04:
                    next_s.seg[1] = pwdata;
                `TSF_OFF_SEG0 + 8'h08:
                    next_s.seg[2] = pwdata;
                `TSF_OFF_IPOLD: next_s.ip_old = pwdata;
                `TSF_OFF_IPNEW: next_s.ip_new = pwdata;
                default:        ;
            endcase
        end
        unique case (s.st)
            S_IDLE:
            begin
                if (go)
                begin
                    next_s.op = tsf_op_t'(pwdata[`TSF_CTRL_OP]);
                    next_s.current_privilege_level = pwdata[`TSF_CTRL_CPL];
                    next_s.outside_event_flag = pwdata[`TSF_CTRL_EXT];
                    next_s.interrupt_descriptor_table = pwdata[`TSF_CTRL_IDT];
                    next_s.t32 = pwdata[`TSF_CTRL_T32];
                    next_s.call = pwdata[`TSF_CTRL_CALL];
                    next_s.tpres = pwdata[`TSF_CTRL_TPRES];
                    next_s.slot = pwdata[`TSF_CTRL_SLOT];
                    next_s.busy = 1'b1;
                    next_s.done = 1'b0;
                    next_s.fault = 1'b0;
                    next_s.new_ctx = 1'b0;
                    next_s.has_code = 1'b0;
                    next_s.vec = 8'h00;
                    next_s.err = 16'h0000;
                    // A load flag left from an earlier switch must not linger
                    next_s.loaded = 1'b0;
                    next_s.st = pwdata[`TSF_CTRL_OP] == 3'(OP_SWITCH)
                                ? S_TSS : S_ONE;
                end
            end
            S_ONE:
            begin
                // Outside a switch the faulting instruction is saved
                unique case (s.op)
                    OP_LOADSEG:
                        if (absent[s.slot])
                            next_s = raise(s,
                                s.slot == 2'd0 ? `TSF_VEC_SS
                                               : `TSF_VEC_NP,
                                mk_err(s.seg[s.slot][15:0],
                                       s.interrupt_descriptor_table, s.outside_event_flag),
                                1'b1, 1'b0, s.ip_old);
                        else
                            next_s = finish(s);
                    OP_LOAD_LOCAL_TABLE_INSTR:
                        if (!s.local_descriptor_table[17])
                            next_s = raise(s, `TSF_VEC_NP,
                                mk_err(s.local_descriptor_table[15:0], s.interrupt_descriptor_table, s.outside_event_flag),
                                1'b1, 1'b0, s.ip_old);
                        else
                            next_s = finish(s);
                    OP_LTR:
                        if (!s.tpres)
                            next_s = raise(s, `TSF_VEC_NP,
                                mk_err(s.task_state_segment[15:0], s.interrupt_descriptor_table, s.outside_event_flag),
                                1'b1, 1'b0, s.ip_old);
                        else
                            next_s = finish(s);
                    OP_GATE:
                        if (!s.tpres)
                            next_s = raise(s, `TSF_VEC_NP,
                                mk_err(s.task_state_segment[15:0], s.interrupt_descriptor_table, s.outside_event_flag),
                                1'b1, 1'b0,
                                s.ip_old);
                        else
                            next_s = finish(s);
                    OP_COPROC:
                        // The retired overrun vector is never produced
                        next_s = raise(s, `TSF_VEC_GP, 16'h0000,
                            1'b1, 1'b0, s.ip_old);
                    default:
                        next_s = finish(s);
                endcase
            end
            S_TSS:
            begin
                if (s.task_state_segment[31:16] < (s.t32 ? `TSF_LIM32 : `TSF_LIM16))
                    next_s = raise(s, `TSF_VEC_TS,
                        mk_err(s.task_state_segment[15:0], 1'b0, s.outside_event_flag),
                        1'b1, 1'b0,
                        s.ip_old);
                else if (!s.tpres)
                    next_s = raise(s, `TSF_VEC_NP,
                        mk_err(s.task_state_segment[15:0], s.interrupt_descriptor_table, s.outside_event_flag),
                        1'b1, 1'b0, s.ip_old);
                else
                    next_s.st = S_COMMIT;
            end
            S_COMMIT:
            begin
                next_s.tr_sel = s.task_state_segment[15:0];
                if (s.call)
                    next_s.link_sel = s.tr_sel;
                next_s.st = S_LOAD;
            end
            S_LOAD:
            begin
                // Every segment register is loaded after the task segment checks and before the local table and segment checks
                next_s.loaded = 1'b1;
                next_s.st = S_LDT;
            end
            S_LDT:
            begin
                if (!s.local_descriptor_table[16] || !s.local_descriptor_table[17])
                    next_s = raise(s, `TSF_VEC_TS,
                        mk_err(s.local_descriptor_table[15:0], 1'b0, s.outside_event_flag),
                        1'b1, 1'b1,
                        s.ip_new);
                else
                begin
                    next_s.idx = 2'd0;
                    next_s.st = S_SEG;
                end
            end
            S_SEG:
            begin
                // First failure ends the walk; later slots go unchecked
                if (bad[s.idx])
                    next_s = raise(s, `TSF_VEC_TS,
                        mk_err(s.seg[s.idx][15:0], 1'b0, s.outside_event_flag),
                        1'b1, 1'b1,
                        s.ip_new);
                else if (absent[s.idx])
                    next_s = raise(s,
                        s.idx == 2'd0 ? `TSF_VEC_SS : `TSF_VEC_NP,
                        mk_err(s.seg[s.idx][15:0], s.interrupt_descriptor_table, s.outside_event_flag),
                        1'b1, 1'b1, s.ip_new);
                else if (s.idx == 2'd2)
                begin
                    next_s = finish(s);
                    next_s.new_ctx = 1'b1;
                    next_s.saved_ip = s.ip_new;
                end
                else
                    next_s.idx = s.idx + 2'd1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign prdata = s.prdata;
    assign exc_valid = s.done && s.fault;
    assign exc_vector = s.vec;
    assign exc_error = s.err;
    assign exc_has_code = s.has_code;
    assign exc_new_ctx = s.new_ctx;
    assign exc_ip = s.saved_ip;
    assign segs_loaded = s.loaded;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_no_overrun: assert property (
        @(posedge clock) disable iff (!rst_n)
        s.fault |-> s.vec != `TSF_VEC_OVERRUN)
        else $error("overrun vector raised");

    chk_coproc_gp: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && s.st == S_ONE && s.op == OP_COPROC
        |=> s.fault && s.vec == `TSF_VEC_GP && s.err == 16'h0000)
        else $error("coprocessor violation not general protection");

    chk_tss_limit: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && s.st == S_TSS && s.t32 && s.task_state_segment[31:16] < 16'h0067
        |=> s.vec == `TSF_VEC_TS && s.err[15:3] == $past(s.task_state_segment[15:3])
            && !s.new_ctx && s.saved_ip == s.ip_old)
        else $error("short task segment not faulted in old context");

    chk_commit_tr: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && s.st == S_COMMIT
        |=> s.tr_sel == s.task_state_segment[15:0] && s.st == S_LOAD)
        else $error("task register not loaded at commit");

    chk_ldt_fault: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && s.st == S_LDT && !s.local_descriptor_table[17]
        |=> s.fault && s.vec == `TSF_VEC_TS && s.new_ctx
            && s.saved_ip == s.ip_new && s.loaded)
        else $error("absent table in switch not bad task state");

    chk_ss_absent: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && s.st == S_SEG && s.idx == 2'd0 && !bad[0] && absent[0]
        |=> s.vec == `TSF_VEC_SS)
        else $error("absent stack not a stack fault");

    chk_ext_flag: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(s.fault) && s.vec != `TSF_VEC_GP
        |-> s.err[0] == s.outside_event_flag)
        else $error("outside event flag wrong in error code");

    chk_one_report: assert property (
        @(posedge clock) disable iff (!rst_n)
        s.done && !go |=> $stable(s.err) && $stable(s.vec))
        else $error("report changed after the first violation");

endmodule
`default_nettype wire

// File: verif/tb_task_switch_segment_fault_checker.sv
/*
 * Self-checking bench of the task switch segment fault checker.
 * Assumes the APB map and check timing of the checker block.
 */
`include "tsf_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_task_switch_segment_fault_checker
    import tsf_pkg::*;
;
    logic        clock = 0, rst_n = 0, ce = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, exc_ip, q, ipo, ipn, tw, lw;
    logic        pready, pslverr, exc_valid, exc_has_code, exc_new_ctx;
    logic        segs_loaded, se, outside_event_flag;
    logic [7:0]  exc_vector;
    logic [15:0] exc_error, tsel, lsel, tr = 16'h0000, lk = 16'h0000;
    logic [1:0]  current_privilege_level;
    logic [31:0] seg [3];
    int          fail_count = 0, check_count = 0, k, n;

    tsf_checker tsf_checker_i (.clock(clock), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exc_valid(exc_valid), .exc_vector(exc_vector),
        .exc_error(exc_error), .exc_has_code(exc_has_code),
        .exc_new_ctx(exc_new_ctx), .exc_ip(exc_ip),
        .segs_loaded(segs_loaded));

    initial
    begin
        forever #50 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] ecode(input logic [15:0] s,
                                          input logic i, input logic x);
        return {s[15:2], i, x};
    endfunction

    function automatic logic [31:0] ctl(input logic [2:0] op,
        input logic [1:0] sl, input logic t32, call, tp, interrupt_descriptor_table);
        return {19'h0, sl, tp, call, t32, interrupt_descriptor_table, outside_event_flag, current_privilege_level, op, 1'b1};
    endfunction

    // Cpl kept below 3 so that cpl+1 never wraps and always exceeds cpl
    task automatic setup();
        current_privilege_level = 2'($urandom % 3);
        outside_event_flag = 1'($urandom);
        tsel = 16'($urandom);
        lsel = 16'($urandom);
        ipo = $urandom;
        ipn = $urandom;
        tw = {16'h0067, tsel};
        lw = {14'h0, 2'b11, lsel};
        for (k = 0; k < 3; k++)
            seg[k] = {10'h0, current_privilege_level, 4'b1010, 14'($urandom), current_privilege_level};
    endtask

    task automatic load();
        apb(1'b1, `TSF_OFF_TSS, tw);
        apb(1'b1, `TSF_OFF_LDT, lw);
        for (n = 0; n < 3; n++)
            apb(1'b1, 8'(`TSF_OFF_SEG0 + 4 * n), seg[n]);
        apb(1'b1, `TSF_OFF_IPOLD, ipo);
        apb(1'b1, `TSF_OFF_IPNEW, ipn);
    endtask

    // m[0] checks the error code, m[1] checks the loaded flag
    task automatic run(input logic [31:0] c, input logic [7:0] v,
        input logic nc, input logic [31:0] ip, input logic [15:0] e,
        input logic ld, input logic [1:0] m);
        logic f;
        f = (v != 8'h00);
        apb(1'b1, `TSF_OFF_CTRL, c);
        // A low clock enable must hold the report back
        if (c[3:1] == 3'd5)
        begin
            ce <= 1'b0;
            repeat (10) @(posedge clock);
            check(exc_valid, 1'b0);
            ce <= 1'b1;
        end
        n = 0;
        do begin apb(1'b0, `TSF_OFF_STATUS, 0); n++; end
        while (q[1] !== 1'b1 && n < 40);
        check({q[15:8], q[4:0]}, {v, f, nc, f, 2'b10});
        if (m[1]) check(q[5], ld);
        check({exc_valid, exc_vector, exc_new_ctx}, {f, v, nc});
        apb(1'b0, `TSF_OFF_ERR, 0);
        if (m[0]) check(q[15:0], e);
        apb(1'b0, `TSF_OFF_SAVEDIP, 0);
        check(q, ip);
    endtask

    initial
    begin
        #(100 * 30000);
        fail_count++;
        conclude();
    end

    initial
    begin
        void'($urandom(89616));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, `TSF_OFF_STATUS, 0);
        check(q, `TSF_RST_WORD);
        apb(1'b0, 8'h40, 0);
        check(se, 1'b1);
        check(q, 32'h0000_0000);
        // Clean switches, then task segment limit boundaries
        for (int j = 0; j < 6; j++)
        begin
            setup();
            if (j >= 2)
                tw[31:16] = (j[0] ? `TSF_LIM32 : `TSF_LIM16) - 16'(j < 4);
            load();
            if (j >= 2 && j < 4)
                run(ctl(3'd0, 2'd0, j[0], 1'b0, 1'b1, 1'b0), `TSF_VEC_TS,
                    1'b0, ipo, ecode(tsel, 1'b0, outside_event_flag), 1'b0, 2'b11);
            else
                run(ctl(3'd0, 2'd0, j[0] | j < 2, j[0], 1'b1, 1'b0), 8'h00,
                    1'b1, ipn, 16'h0000, 1'b1, 2'b11);
            apb(1'b0, `TSF_OFF_TASK, 0);
            // A call links back to the task that ran before it
            if (j < 2 || j > 3)
            begin
                if (j[0]) lk = tr;
                tr = tsel;
            end
            check(q, {lk, tr});
        end
        // Local table invalid or absent during a switch
        for (int j = 0; j < 2; j++)
        begin
            setup();
            lw[16 + j] = 1'b0;
            load();
            run(ctl(3'd0, 2'd0, 1'b1, 1'b1, 1'b1, 1'b0), `TSF_VEC_TS, 1'b1,
                ipn, ecode(lsel, 1'b0, outside_event_flag), 1'b1, 2'b11);
        end
        // Segment faults; a second bad data slot must stay unreported
        for (int j = 0; j < 13; j++)
        begin
            setup();
            k = (j < 4) ? 0 : (j < 8) ? 1 : (j < 10) ? 2 : j - 10;
            if (j < 8) seg[2][16] = 1'b1;
            case (j)
                0, 4, 8: seg[k][16] = 1'b1;
                1, 5, 9: seg[k][17] = 1'b0;
                2, 6:    seg[k][21:20] = current_privilege_level + 2'd1;
                3:       seg[k][1:0] = current_privilege_level + 2'd1;
                7:       seg[k][21:18] = {current_privilege_level + 2'd1, 2'b11};
                default: seg[k][19] = 1'b0;
            endcase
            load();
            run(ctl(3'd0, 2'd0, 1'b1, 1'b0, 1'b1, 1'b0),
                j < 10 ? `TSF_VEC_TS : (k == 0 ? `TSF_VEC_SS : `TSF_VEC_NP),
                1'b1, ipn, ecode(seg[k][15:0], 1'b0, outside_event_flag), 1'b1,
                2'b11);
        end
        // Instruction-level operations outside a switch, then a switch to an absent task segment
        for (int j = 0; j < 6; j++)
        begin
            setup();
            lw[17] = 1'b0;
            seg[1][19] = 1'b0;
            load();
            case (j)
                0: run(ctl(3'd2, 2'd0, 1'b1, 1'b0, 1'b1, 1'b0), `TSF_VEC_NP,
                    1'b0, ipo, ecode(lsel, 1'b0, outside_event_flag), 1'b0, 2'b11);
                1: run(ctl(3'd3, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0), `TSF_VEC_NP,
                    1'b0, ipo, ecode(tsel, 1'b0, outside_event_flag), 1'b0, 2'b11);
                2: run(ctl(3'd4, 2'd0, 1'b1, 1'b0, 1'b0, 1'b1), `TSF_VEC_NP,
                    1'b0, ipo, ecode(tsel, 1'b1, outside_event_flag), 1'b0,
                    2'b11);
                3: run(ctl(3'd5, 2'd0, 1'b1, 1'b0, 1'b1, 1'b0), `TSF_VEC_GP,
                    1'b0, ipo, 16'h0000, 1'b0, 2'b11);
                4: run(ctl(3'd1, 2'd1, 1'b1, 1'b0, 1'b1, 1'b0),
                    `TSF_VEC_NP, 1'b0, ipo, ecode(seg[1][15:0], 1'b0, outside_event_flag),
                    1'b0, 2'b11);
                default: run(ctl(3'd0, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0),
                    `TSF_VEC_NP, 1'b0, ipo, ecode(tsel, 1'b0, outside_event_flag),
                    1'b0, 2'b11);
            endcase
            if (j == 2) check(exc_error[1], 1'b1);
        end
        conclude();
    end
endmodule
`default_nettype wire
